// File: inc/oag_pkg.sv
// Operand address generator package: addressing modes, widths, layout constants.
// Assumes the decode stage presents one operand request at a time.
package oag_pkg;
    localparam int OAG_RF_AW = 12;
    localparam int OAG_PM_AW = 16;
    localparam logic [7:0] OAG_ESC_HI = 8'hE0;
    localparam logic [3:0] OAG_ESC_NIB = 4'hE;
    localparam logic [15:0] OAG_PC_RST = 16'h0000;
    localparam logic [11:0] OAG_RF_RST = 12'h000;

    typedef enum logic [3:0] {
        OAG_M_WREG = 4'h0,
        OAG_M_WPAIR = 4'h1,
        OAG_M_REG = 4'h2,
        OAG_M_RPAIR = 4'h3,
        OAG_M_IND_WREG = 4'h4,
        OAG_M_IND_WPAIR = 4'h5,
        OAG_M_IND_REG = 4'h6,
        OAG_M_IND_RPAIR = 4'h7,
        OAG_M_INDEXED = 4'h8,
        OAG_M_ABS_JUMP = 4'h9,
        OAG_M_REL_JUMP = 4'hA,
        OAG_M_IMMEDIATE = 4'hB
    } oag_mode_t;

    typedef enum logic [5:0] {
        OAG_S_IDLE = 6'b000001,
        OAG_S_PTR_HI = 6'b000010,
        OAG_S_PTR_LO = 6'b000100,
        OAG_S_IMM = 6'b001000,
        OAG_S_DONE = 6'b010000,
        OAG_S_ERR = 6'b100000
    } oag_state_t;
endpackage

// File: src/oag_reg_map.sv
// Combinational 8-bit register address mapper with escaped window.
// Assumes the pointer is stable while the operand is mapped.
`timescale 1ns/100ps
module oag_reg_map (
    input wire logic [7:0] register_bank_pointer_i,
    input wire logic [7:0] operand_i,
    input wire logic is_working_i,
    output logic [11:0] addr_o
);
    import oag_pkg::*;

    always_comb begin
        if (is_working_i || operand_i[7:4] == OAG_ESC_NIB) begin
            addr_o = {register_bank_pointer_i[3:0], register_bank_pointer_i[7:4],
                      operand_i[3:0]};
        end else begin
            addr_o = {register_bank_pointer_i[3:0], operand_i};
        end
    end
endmodule

// File: src/oag_top.sv
// Operand address generator: resolves operand effective addresses and jump targets.
// Assumes register file and program memory answer a read while its strobe stands.
// Read data is therefore sampled on the edge that ends the strobe cycle.
`timescale 1ns/100ps
module oag_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire oag_pkg::oag_mode_t mode_i,
    input wire logic [7:0] register_bank_pointer_i,
    input wire logic [7:0] operand_i,
    input wire logic [7:0] index_base_i,
    input wire logic pair_to_program_i,
    input wire logic [15:0] absolute_target_i,
    input wire logic [7:0] relative_offset_i,
    input wire logic [15:0] next_pc_i,
    input wire logic [7:0] rf_rdata_i,
    input wire logic [7:0] pm_rdata_i,
    output logic rf_rd_o,
    output logic [11:0] rf_addr_o,
    output logic pm_rd_o,
    output logic [15:0] pm_addr_o,
    output logic done_o,
    output logic error_o,
    output logic ea_is_program_o,
    output logic [11:0] ea_rf_o,
    output logic [15:0] ea_pm_o,
    output logic [7:0] immediate_value_o,
    output logic pc_load_o,
    output logic [15:0] pc_o
);
    import oag_pkg::*;

    oag_state_t state_q, state_d;
    oag_mode_t mode_q, mode_d;
    logic [7:0] ptr_q, ptr_d;
    logic [11:0] pair_addr_q, pair_addr_d;
    logic [7:0] hi_byte_q, hi_byte_d;
    logic rf_rd_q, rf_rd_d;
    logic [11:0] rf_addr_q, rf_addr_d;
    logic pm_rd_q, pm_rd_d;
    logic [15:0] pm_addr_q, pm_addr_d;
    logic done_q, done_d;
    logic error_q, error_d;
    logic prog_q, prog_d;
    logic [11:0] ea_rf_q, ea_rf_d;
    logic [15:0] ea_pm_q, ea_pm_d;
    logic [7:0] imm_q, imm_d;
    logic pc_load_q, pc_load_d;
    logic [15:0] pc_q, pc_d;
    logic [11:0] map_addr;
    logic [7:0] idx_sum;
    logic map_working;

    // Working-register modes and the indexed mode ignore the operand high nibble
    assign map_working = (mode_i == OAG_M_WREG) || (mode_i == OAG_M_WPAIR)
                         || (mode_i == OAG_M_IND_WREG) || (mode_i == OAG_M_IND_WPAIR)
                         || (mode_i == OAG_M_INDEXED);

    oag_reg_map u_map (
        .register_bank_pointer_i(register_bank_pointer_i),
        .operand_i(operand_i),
        .is_working_i(map_working),
        .addr_o(map_addr)
    );

    // Eight-bit wrap is intended; carry out is dropped
    assign idx_sum = index_base_i + rf_rdata_i;

    function automatic logic [11:0] odd_of(input logic [11:0] a);
        odd_of = {a[11:1], 1'b1};
    endfunction

    // Only working pairs are refused when odd; 8-bit pair operands pass unchanged
    function automatic logic odd_working_pair(input oag_mode_t m, input logic [7:0] op);
        odd_working_pair = ((m == OAG_M_WPAIR) || (m == OAG_M_IND_WPAIR)) && op[0];
    endfunction

    // Sign extension keeps the wrap of the 16-bit program counter
    function automatic logic [15:0] sext16(input logic [7:0] v);
        sext16 = {{8{v[7]}}, v};
    endfunction

    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        ptr_d = ptr_q;
        pair_addr_d = pair_addr_q;
        hi_byte_d = hi_byte_q;
        rf_rd_d = 1'b0;
        rf_addr_d = rf_addr_q;
        pm_rd_d = 1'b0;
        pm_addr_d = pm_addr_q;
        done_d = 1'b0;
        error_d = 1'b0;
        prog_d = prog_q;
        ea_rf_d = ea_rf_q;
        ea_pm_d = ea_pm_q;
        imm_d = imm_q;
        pc_load_d = 1'b0;
        pc_d = pc_q;
        unique case (state_q)
            OAG_S_IDLE: begin
                if (start_i) begin
                    mode_d = mode_i;
                    ptr_d = register_bank_pointer_i;
                    prog_d = 1'b0;
                    unique case (mode_i)
                        OAG_M_WREG, OAG_M_REG: begin
                            ea_rf_d = map_addr;
                            state_d = OAG_S_DONE;
                        end
                        OAG_M_WPAIR, OAG_M_RPAIR: begin
                            if (odd_working_pair(mode_i, operand_i)) begin
                                state_d = OAG_S_ERR;
                            end else begin
                                ea_rf_d = map_addr;
                                state_d = OAG_S_DONE;
                            end
                        end
                        OAG_M_IND_WREG, OAG_M_IND_REG, OAG_M_INDEXED: begin
                            rf_rd_d = 1'b1;
                            rf_addr_d = map_addr;
                            state_d = OAG_S_PTR_LO;
                        end
                        OAG_M_IND_WPAIR, OAG_M_IND_RPAIR: begin
                            if (odd_working_pair(mode_i, operand_i)) begin
                                state_d = OAG_S_ERR;
                            end else begin
                                pair_addr_d = map_addr;
                                rf_rd_d = 1'b1;
                                rf_addr_d = map_addr;
                                state_d = OAG_S_PTR_HI;
                            end
                        end
                        OAG_M_ABS_JUMP: begin
                            pc_d = absolute_target_i;
                            pc_load_d = 1'b1;
                            done_d = 1'b1;
                        end
                        OAG_M_REL_JUMP: begin
                            pc_d = next_pc_i + sext16(relative_offset_i);
                            pc_load_d = 1'b1;
                            done_d = 1'b1;
                        end
                        OAG_M_IMMEDIATE: begin
                            pm_rd_d = 1'b1;
                            pm_addr_d = next_pc_i;
                            state_d = OAG_S_IMM;
                        end
                        default: begin
                            state_d = OAG_S_ERR;
                        end
                    endcase
                end
            end
            OAG_S_PTR_HI: begin
                hi_byte_d = rf_rdata_i;
                rf_rd_d = 1'b1;
                rf_addr_d = odd_of(pair_addr_q);
                state_d = OAG_S_PTR_LO;
            end
            OAG_S_PTR_LO: begin
                state_d = OAG_S_DONE;
                unique case (mode_q)
                    OAG_M_IND_WREG, OAG_M_IND_REG: begin
                        ea_rf_d = {ptr_q[3:0], rf_rdata_i};
                    end
                    OAG_M_INDEXED: begin
                        ea_rf_d = {ptr_q[3:0], idx_sum};
                    end
                    OAG_M_IND_WPAIR: begin
                        prog_d = pair_to_program_i;
                        ea_pm_d = {hi_byte_q, rf_rdata_i};
                        ea_rf_d = {hi_byte_q[3:0], rf_rdata_i};
                    end
                    default: begin
                        prog_d = 1'b1;
                        ea_pm_d = {hi_byte_q, rf_rdata_i};
                    end
                endcase
            end
            OAG_S_IMM: begin
                imm_d = pm_rdata_i;
                state_d = OAG_S_DONE;
            end
            OAG_S_DONE: begin
                done_d = 1'b1;
                state_d = OAG_S_IDLE;
            end
            OAG_S_ERR: begin
                error_d = 1'b1;
                state_d = OAG_S_IDLE;
            end
            default: begin
                state_d = OAG_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= OAG_S_IDLE;
            mode_q <= OAG_M_WREG;
            ptr_q <= 8'h00;
            pair_addr_q <= OAG_RF_RST;
            hi_byte_q <= 8'h00;
            rf_rd_q <= 1'b0;
            rf_addr_q <= OAG_RF_RST;
            pm_rd_q <= 1'b0;
            pm_addr_q <= OAG_PC_RST;
            done_q <= 1'b0;
            error_q <= 1'b0;
            prog_q <= 1'b0;
            ea_rf_q <= OAG_RF_RST;
            ea_pm_q <= OAG_PC_RST;
            imm_q <= 8'h00;
            pc_load_q <= 1'b0;
            pc_q <= OAG_PC_RST;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            ptr_q <= ptr_d;
            pair_addr_q <= pair_addr_d;
            hi_byte_q <= hi_byte_d;
            rf_rd_q <= rf_rd_d;
            rf_addr_q <= rf_addr_d;
            pm_rd_q <= pm_rd_d;
            pm_addr_q <= pm_addr_d;
            done_q <= done_d;
            error_q <= error_d;
            prog_q <= prog_d;
            ea_rf_q <= ea_rf_d;
            ea_pm_q <= ea_pm_d;
            imm_q <= imm_d;
            pc_load_q <= pc_load_d;
            pc_q <= pc_d;
        end
    end

    assign rf_rd_o = rf_rd_q;
    assign rf_addr_o = rf_addr_q;
    assign pm_rd_o = pm_rd_q;
    assign pm_addr_o = pm_addr_q;
    assign done_o = done_q;
    assign error_o = error_q;
    assign ea_is_program_o = prog_q;
    assign ea_rf_o = ea_rf_q;
    assign ea_pm_o = ea_pm_q;
    assign immediate_value_o = imm_q;
    assign pc_load_o = pc_load_q;
    assign pc_o = pc_q;
endmodule

// File: testbench/oag_mem_model.sv
// Register file and program memory seen from the address generator.
// Assumes read data must stand while the read strobe stands, in the same cycle.
`timescale 1ns/100ps
module oag_mem_model (
    input wire logic rf_rd_i,
    input wire logic [11:0] rf_addr_i,
    input wire logic pm_rd_i,
    input wire logic [15:0] pm_addr_i,
    output logic [7:0] rf_rdata_o,
    output logic [7:0] pm_rdata_o
);
    function automatic logic [7:0] rf_val(logic [11:0] a);
        return a[7:0] + {a[11:8], 4'h9};
    endfunction
    function automatic logic [7:0] pm_val(logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5A;
    endfunction
    // Inverted data when idle, so a capture outside the strobe shows up
    always_comb begin
        rf_rdata_o = rf_rd_i ? rf_val(rf_addr_i) : ~rf_val(rf_addr_i);
        pm_rdata_o = pm_rd_i ? pm_val(pm_addr_i) : ~pm_val(pm_addr_i);
    end
endmodule

// File: testbench/oag_monitor.sv
// Protocol and address checks on the generator's ports.
// Assumes start_i is only raised while the block is idle.
`timescale 1ns/100ps
module oag_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire oag_pkg::oag_mode_t mode_i,
    input wire logic [7:0] register_bank_pointer_i,
    input wire logic [7:0] operand_i,
    input wire logic [7:0] relative_offset_i,
    input wire logic [15:0] absolute_target_i,
    input wire logic [15:0] next_pc_i,
    input wire logic rf_rd_o,
    input wire logic [11:0] rf_addr_o,
    input wire logic pm_rd_o,
    input wire logic [15:0] pm_addr_o,
    input wire logic done_o,
    input wire logic error_o,
    input wire logic ea_is_program_o,
    input wire logic [11:0] ea_rf_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_o
);
    import oag_pkg::*;
    logic [7:0] ptr_q, op_q, off_q;
    logic [15:0] npc_q, tgt_q;
    always_ff @(posedge clk_sys_i) begin
        if (start_i) begin
            ptr_q <= register_bank_pointer_i;
            op_q <= operand_i;
            off_q <= relative_offset_i;
            npc_q <= next_pc_i;
            tgt_q <= absolute_target_i;
        end
    end
    function automatic logic [11:0] map8(logic [7:0] p, logic [7:0] a);
        return (a[7:4] == OAG_ESC_NIB) ? {p[3:0], p[7:4], a[3:0]} : {p[3:0], a};
    endfunction
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_pair_reads;
        rf_rd_o && !rf_addr_o[0] ##1 rf_rd_o && rf_addr_o == ($past(rf_addr_o) | 12'h001);
    endsequence
    a_wreg_addr: assert property (start_i && mode_i == OAG_M_WREG |-> ##2 done_o
        && ea_rf_o == {ptr_q[3:0], ptr_q[7:4], op_q[3:0]}) else $error("working address");
    a_reg_map: assert property (start_i && mode_i == OAG_M_REG |-> ##2 done_o
        && ea_rf_o == map8(ptr_q, op_q)) else $error("register address");
    a_odd_pair: assert property (start_i && mode_i == OAG_M_WPAIR && operand_i[0]
        |-> ##2 error_o && !done_o) else $error("odd pair accepted");
    a_pair_order: assert property (start_i && mode_i == OAG_M_IND_RPAIR
        |=> s_pair_reads ##2 done_o && ea_is_program_o) else $error("pair read order");
    a_abs_jump: assert property (start_i && mode_i == OAG_M_ABS_JUMP
        |=> pc_load_o && done_o && pc_o == tgt_q) else $error("absolute target");
    a_rel_jump: assert property (start_i && mode_i == OAG_M_REL_JUMP
        |=> pc_load_o && pc_o == npc_q + {{8{off_q[7]}}, off_q}) else $error("relative target");
    a_imm_fetch: assert property (start_i && mode_i == OAG_M_IMMEDIATE
        |=> pm_rd_o && pm_addr_o == npc_q ##2 done_o) else $error("immediate fetch");
    a_done_pulse: assert property (done_o |=> !done_o) else $error("done longer than a cycle");
    a_load_done: assert property (pc_load_o |-> done_o) else $error("load without done");
endmodule
bind oag_top oag_monitor u_mon (.clk_sys_i, .rst_i, .start_i, .mode_i,
    .register_bank_pointer_i, .operand_i, .relative_offset_i, .absolute_target_i, .next_pc_i,
    .rf_rd_o, .rf_addr_o, .pm_rd_o, .pm_addr_o, .done_o, .error_o, .ea_is_program_o,
    .ea_rf_o, .pc_load_o, .pc_o);

// File: testbench/test_oag_top.sv
// Self-checking bench: corner and random operands over every mode.
// Assumes the memory model's contents functions are fixed.
`timescale 1ns/100ps
module test_oag_top;
    import oag_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    logic p2p = 1'b0;
    oag_mode_t mode_i = OAG_M_WREG;
    oag_mode_t m;
    logic [7:0] ptr = 8'h00, opnd = 8'h00, base = 8'h00, off = 8'h00, rfd, pmd, imm_o;
    logic [15:0] tgt = 16'h0000, npc = 16'h0000, pma, ea_pm, pc;
    logic [11:0] rfa, ea_rf;
    logic rf_rd, pm_rd, done_o, error_o, is_prog, pc_load;
    logic [7:0] edge_ops [4] = '{8'hDF, 8'hE0, 8'hEF, 8'hF0};
    int errors = 0;
    int comparisons = 0;
    integer seed = 32'h1824;
    oag_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i), .mode_i(mode_i),
        .register_bank_pointer_i(ptr), .operand_i(opnd), .index_base_i(base),
        .pair_to_program_i(p2p), .absolute_target_i(tgt), .relative_offset_i(off),
        .next_pc_i(npc), .rf_rdata_i(rfd), .pm_rdata_i(pmd), .rf_rd_o(rf_rd), .rf_addr_o(rfa),
        .pm_rd_o(pm_rd), .pm_addr_o(pma), .done_o(done_o), .error_o(error_o),
        .ea_is_program_o(is_prog), .ea_rf_o(ea_rf), .ea_pm_o(ea_pm),
        .immediate_value_o(imm_o), .pc_load_o(pc_load), .pc_o(pc));
    oag_mem_model u_mem (.rf_rd_i(rf_rd), .rf_addr_i(rfa),
        .pm_rd_i(pm_rd), .pm_addr_i(pma), .rf_rdata_o(rfd), .pm_rdata_o(pmd));
    task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [11:0] map8(logic [7:0] p, logic [7:0] a);
        return (a[7:4] == 4'hE) ? {p[3:0], p[7:4], a[3:0]} : {p[3:0], a};
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic run(oag_mode_t md);
        logic [11:0] w, a;
        logic [7:0] hi, lo;
        int n;
        logic [15:0] e;
        w = {ptr[3:0], ptr[7:4], opnd[3:0]};
        a = map8(ptr, opnd);
        @(negedge clk_sys_i);
        mode_i = md;
        start_i = 1'b1;
        @(negedge clk_sys_i);
        start_i = 1'b0;
        for (n = 0; n < 10 && done_o !== 1'b1 && error_o !== 1'b1; n++) @(negedge clk_sys_i);
        chk("handshake", 16'(n < 10), 16'h0001);
        hi = u_mem.rf_val(w);
        lo = u_mem.rf_val(w | 12'h001);
        // Odd working pairs and undefined mode codes must end in error
        if ((opnd[0] && md inside {OAG_M_WPAIR, OAG_M_IND_WPAIR}) || md > OAG_M_IMMEDIATE) begin
            chk("error", 16'(error_o), 16'h0001);
        end else begin
            case (md)
                OAG_M_WREG, OAG_M_WPAIR: begin
                    chk("ea_rf", 16'(ea_rf), 16'(w));
                end
                OAG_M_REG, OAG_M_RPAIR: begin
                    chk("ea_rf", 16'(ea_rf), 16'(a));
                end
                OAG_M_IND_WREG: begin
                    chk("ea_rf", 16'(ea_rf), 16'({ptr[3:0], hi}));
                end
                OAG_M_IND_WPAIR: begin
                    e = p2p ? {hi, lo} : 16'({hi[3:0], lo});
                    chk("ea", p2p ? ea_pm : 16'(ea_rf), e);
                    chk("prog", 16'(is_prog), 16'(p2p));
                end
                OAG_M_IND_REG: begin
                    e = 16'({ptr[3:0], u_mem.rf_val(a)});
                    chk("ea_rf", 16'(ea_rf), e);
                end
                OAG_M_IND_RPAIR: begin
                    e = {u_mem.rf_val(a), u_mem.rf_val(a | 12'h001)};
                    chk("ea_pm", ea_pm, e);
                    chk("prog", 16'(is_prog), 16'h0001);
                end
                OAG_M_INDEXED: begin
                    chk("ea_rf", 16'(ea_rf), 16'({ptr[3:0], 8'(base + hi)}));
                end
                OAG_M_ABS_JUMP: begin
                    chk("pc", pc, tgt);
                    chk("pc_load", 16'(pc_load), 16'h0001);
                end
                OAG_M_REL_JUMP: chk("pc", pc, npc + {{8{off[7]}}, off});
                default: chk("imm", 16'(imm_o), 16'(u_mem.pm_val(npc)));
            endcase
        end
    endtask
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #(40 * 8000);
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        ptr = 8'h5A;
        foreach (edge_ops[i]) begin
            opnd = edge_ops[i];
            run(OAG_M_REG);
            opnd[0] = 1'b0;
            run(OAG_M_IND_RPAIR);
        end
        opnd = 8'h0F;
        run(OAG_M_WPAIR);
        run(OAG_M_IND_WPAIR);
        off = 8'h7F;
        run(OAG_M_REL_JUMP);
        off = 8'h80;
        run(OAG_M_REL_JUMP);
        tgt = 16'hFFFF;
        run(OAG_M_ABS_JUMP);
        run(oag_mode_t'(4'hC));
        repeat (300) begin
            {ptr, opnd, base, off} = $random(seed);
            {tgt, npc} = $random(seed);
            p2p = 1'($random(seed));
            m = oag_mode_t'(4'(($random(seed) & 32'h7FFFFFFF) % 12));
            if (m == OAG_M_IND_RPAIR) opnd[0] = 1'b0;
            run(m);
        end
        report_and_stop();
    end
endmodule
